// File: include/pis_pkg.sv
// package with register map, field positions and carrier types for the pin irq source selector
package pis_pkg;
  // printed register indices; the byte address is four times the index
  localparam logic [31:0] PIS_IDX_AUX_SEL = 32'h00ffe10c;
  localparam logic [31:0] PIS_IDX_PAIR_SEL = 32'h00ffe10e;
  localparam logic [31:0] PIS_IDX_EDGE_POL = 32'h00ffe10f;
  localparam logic [31:0] PIS_IDX_PC_SEL = 32'h00ffe12e;
  localparam logic [31:0] PIS_IDX_PENDING = 32'h00ffe140;
  localparam logic [31:0] PIS_IDX_MASK = 32'h00ffe141;
  localparam logic [31:0] PIS_IDX_SW_SET = 32'h00ffe142;
  localparam logic [31:0] PIS_IDX_PRIORITY = 32'h00ffe143;
  localparam logic [31:0] PIS_IDX_EXC = 32'h00ffe144;
  localparam logic [31:0] PIS_IDX_VECTOR = 32'h00ffe145;
  // field positions
  localparam int PIS_AUX_CMP_BIT = 7;
  localparam int PIS_AUX_DBG_BIT = 0;
  localparam logic [7:0] PIS_AUX_WMASK = 8'h81;
  localparam logic [7:0] PIS_PC_WMASK = 8'h0f;
  localparam int PIS_NUM_AD = 8;
  localparam int PIS_NUM_PC = 4;
  localparam int PIS_NUM_LINES = 12;
  localparam int PIS_PC_BASE = 8;
  // reset values
  localparam logic [7:0] PIS_SEL_RESET = 8'h00;
  localparam logic [11:0] PIS_LINES_RESET = 12'h000;
  localparam logic [23:0] PIS_PRIO_RESET = 24'h000000;
  // priority level codes; code 3 acts as the top level
  localparam logic [1:0] PIS_LVL_LOW = 2'h0;
  localparam logic [1:0] PIS_LVL_MID = 2'h1;
  localparam logic [1:0] PIS_LVL_HIGH = 2'h2;
  localparam logic [1:0] PIS_LVL_ALIAS = 2'h3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } pis_apb_req_s;

  typedef struct packed {
    logic [7:0] port_a;
    logic [7:0] port_d;
    logic [3:0] port_c;
    logic comparator;
  } pis_pins_s;
endpackage

// File: src/pis_irq_select.sv
// pin irq source selector with pending, mask, priority and apb register file
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pis_irq_select
  import pis_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire pis_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pis_pins_s pins,
  input wire logic dbg_req,
  input wire logic [3:0] dma_done,
  input wire logic sys_exc,
  input wire logic irq_ack,
  output logic irq_out,
  output logic [3:0] irq_id,
  output logic [1:0] irq_level,
  output logic exc_out
);
  localparam int PW = 21;

  logic [7:0] aux_sel_reg;
  logic [7:0] pair_sel_reg;
  logic [7:0] edge_pol_reg;
  logic [7:0] pc_sel_reg;
  logic [11:0] pend_reg;
  logic [11:0] pend_next;
  logic [11:0] mask_reg;
  logic [23:0] prio_reg;
  logic exc_pend_reg;
  logic [PW-1:0] s1_reg;
  logic [PW-1:0] s2_reg;
  logic [PW-1:0] prev_reg;
  logic [PW-1:0] rise;
  logic [PW-1:0] fall;
  logic [11:0] evt;
  logic [11:0] active;
  logic [11:0] sw_set;
  logic [11:0] w1c;
  logic [11:0] ack_clr;
  logic [3:0] best_id;
  logic [1:0] best_lvl;
  logic found;
  logic [3:0] ln;
  logic [1:0] lv;
  logic [31:0] rd_data;
  logic hit;
  logic access;
  logic wr_fire;
  logic [11:0] set_vec;
  logic [11:0] clr_vec;
  logic [6:0] vec_word;
  logic exc_clr;
  logic [31:0] widx;

  // apb decode; the printed offset is an index, so drop the two byte bits
  assign widx = {2'b00, apb_req.paddr[31:2]};
  assign access = apb_req.psel & apb_req.penable;
  assign wr_fire = access & pready & apb_req.pwrite;

  // one write strobe per register, each live only in the completing cycle;
  // decoding once keeps every register block from repeating the compare
  logic wr_aux;
  logic wr_pair;
  logic wr_edge;
  logic wr_pc;
  logic wr_mask;
  logic wr_prio;
  logic wr_swset;
  logic wr_pend;
  logic wr_exc;
  assign wr_aux = wr_fire && (widx == PIS_IDX_AUX_SEL);
  assign wr_pair = wr_fire && (widx == PIS_IDX_PAIR_SEL);
  assign wr_edge = wr_fire && (widx == PIS_IDX_EDGE_POL);
  assign wr_pc = wr_fire && (widx == PIS_IDX_PC_SEL);
  assign wr_mask = wr_fire && (widx == PIS_IDX_MASK);
  assign wr_prio = wr_fire && (widx == PIS_IDX_PRIORITY);
  assign wr_swset = wr_fire && (widx == PIS_IDX_SW_SET);
  assign wr_pend = wr_fire && (widx == PIS_IDX_PENDING);
  assign wr_exc = wr_fire && (widx == PIS_IDX_EXC);

  // one wait state: pready is high in the second access cycle, drops after completion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  // read data and error are captured together with pready
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (access & ~pready) begin
      prdata <= apb_req.pwrite ? 32'h00000000 : rd_data;
      pslverr <= ~hit;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // read mux; reserved bits read as zero
  always_comb begin
    rd_data = 32'h00000000;
    hit = 1'b1;
    unique case (widx)
      PIS_IDX_AUX_SEL: rd_data = {24'h000000, aux_sel_reg};
      PIS_IDX_PAIR_SEL: rd_data = {24'h000000, pair_sel_reg};
      PIS_IDX_EDGE_POL: rd_data = {24'h000000, edge_pol_reg};
      PIS_IDX_PC_SEL: rd_data = {24'h000000, pc_sel_reg};
      PIS_IDX_PENDING: rd_data = {20'h00000, pend_reg};
      PIS_IDX_MASK: rd_data = {20'h00000, mask_reg};
      PIS_IDX_SW_SET: rd_data = 32'h00000000;
      PIS_IDX_PRIORITY: rd_data = {8'h00, prio_reg};
      PIS_IDX_EXC: rd_data = {31'h00000000, exc_pend_reg};
      PIS_IDX_VECTOR: rd_data = {25'h0000000, vec_word};
      default: hit = 1'b0;
    endcase
  end

  // aux source select; only bits 7 and 0 are writable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aux_sel_reg <= PIS_SEL_RESET;
    end else if (wr_aux) begin
      aux_sel_reg <= apb_req.pwdata[7:0] & PIS_AUX_WMASK;
    end
  end

  // port pair select
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pair_sel_reg <= PIS_SEL_RESET;
    end else if (wr_pair) begin
      pair_sel_reg <= apb_req.pwdata[7:0];
    end
  end

  // edge polarity select
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      edge_pol_reg <= PIS_SEL_RESET;
    end else if (wr_edge) begin
      edge_pol_reg <= apb_req.pwdata[7:0];
    end
  end

  // port c source select; upper nibble stays zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pc_sel_reg <= PIS_SEL_RESET;
    end else if (wr_pc) begin
      pc_sel_reg <= apb_req.pwdata[7:0] & PIS_PC_WMASK;
    end
  end

  // mask register gates pending lines onto irq_out
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_reg <= PIS_LINES_RESET;
    end else if (wr_mask) begin
      mask_reg <= apb_req.pwdata[11:0];
    end
  end

  // two priority bits per line, line n at bits 2n+1..2n
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prio_reg <= PIS_PRIO_RESET;
    end else if (wr_prio) begin
      prio_reg <= apb_req.pwdata[23:0];
    end
  end

  // pin synchronisers; only the second stage and prev_reg are used downstream
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      prev_reg <= s2_reg;
    end
  end

  // one-cycle edge pulses per synchronised pin
  assign rise = s2_reg & ~prev_reg;
  assign fall = ~s2_reg & prev_reg;

  // per-line event selection; bit layout of s2 follows pis_pins_s
  // comparator bit 0, port c bits 4..1, port d bits 12..5, port a bits 20..13
  genvar g;
  generate
    for (g = 0; g < PIS_NUM_AD; g++) begin : g_ad
      logic pin_evt;
      // one edge pick per line: port choice first, then polarity
      pis_line_edge edge_u (
        .pair_bit(pair_sel_reg[g]),
        .pol_bit(edge_pol_reg[g]),
        .rise_a(rise[13 + g]),
        .fall_a(fall[13 + g]),
        .rise_d(rise[5 + g]),
        .fall_d(fall[5 + g]),
        .evt(pin_evt)
      );
      if (g == PIS_AUX_CMP_BIT) begin : g_cmp
        logic cmp_evt;
        // comparator fires on both transitions
        pis_both_edge cmp_u (
          .rise_in(rise[0]),
          .fall_in(fall[0]),
          .evt(cmp_evt)
        );
        assign evt[g] = aux_sel_reg[PIS_AUX_CMP_BIT] ? cmp_evt : pin_evt;
      end else if (g == PIS_AUX_DBG_BIT) begin : g_dbg
        assign evt[g] = aux_sel_reg[PIS_AUX_DBG_BIT] ? dbg_req : pin_evt;
      end else begin : g_pin
        assign evt[g] = pin_evt;
      end
    end
    for (g = 0; g < PIS_NUM_PC; g++) begin : g_pc
      logic pc_evt;
      // port c pins use both edges, dma completions are pulses
      pis_both_edge pc_u (
        .rise_in(rise[1 + g]),
        .fall_in(fall[1 + g]),
        .evt(pc_evt)
      );
      assign evt[PIS_PC_BASE + g] = pc_sel_reg[g] ? pc_evt : dma_done[g];
    end
  endgenerate

  // software set and write-one-to-clear strobes
  assign sw_set = wr_swset ? apb_req.pwdata[11:0] : 12'h000;
  assign w1c = wr_pend ? apb_req.pwdata[11:0] : 12'h000;
  // the ack names the line the cpu saw; a stale id only costs one extra clear
  assign ack_clr = irq_ack ? (12'h001 << irq_id) : 12'h000;

  // pending: a new event wins over a clear in the same cycle
  // everything that sets a pending bit this cycle
  assign set_vec = evt | sw_set;
  // everything that clears one; a set in the same cycle still wins
  assign clr_vec = w1c | ack_clr;
  assign pend_next = (pend_reg & ~clr_vec) | set_vec;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_reg <= PIS_LINES_RESET;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // exception flag ignores the mask register entirely
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exc_pend_reg <= 1'b0;
    end else begin
      exc_pend_reg <= sys_exc | (exc_pend_reg & ~exc_clr);
    end
  end

  // software clears the exception flag by writing a one to bit 0;
  // a new exception in that same cycle keeps it set
  assign exc_clr = wr_exc & apb_req.pwdata[0];

  // only unmasked pending lines take part in arbitration
  assign active = pend_reg & mask_reg;

  // vector word as software reads it
  assign vec_word = {irq_out, irq_level, irq_id};

  // arbitration scans lowest fixed order first, so later equal levels win;
  // port c lines rank below port a/d lines, within each group a higher line number ranks higher
  always_comb begin
    best_id = 4'h0;
    best_lvl = PIS_LVL_LOW;
    found = 1'b0;
    ln = 4'h0;
    lv = PIS_LVL_LOW;
    for (int i = 0; i < PIS_NUM_LINES; i++) begin
      ln = (i < PIS_NUM_PC) ? 4'(i + PIS_PC_BASE) : 4'(i - PIS_NUM_PC);
      lv = prio_reg[{ln, 1'b0} +: 2];
      if (lv == PIS_LVL_ALIAS) begin
        lv = PIS_LVL_HIGH;
      end
      if (active[ln] && (!found || lv >= best_lvl)) begin
        best_id = ln;
        best_lvl = lv;
        found = 1'b1;
      end
    end
  end

  // registered interrupt request and vector; pending bits are never touched here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_out <= 1'b0;
      irq_id <= 4'h0;
      irq_level <= PIS_LVL_LOW;
    end else begin
      irq_out <= found;
      irq_id <= best_id;
      irq_level <= best_lvl;
    end
  end

  // exception output is a registered level from sys_exc or the sticky flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exc_out <= 1'b0;
    end else begin
      exc_out <= sys_exc | exc_pend_reg;
    end
  end
endmodule

// per-line edge pick: port A or port D pin, then rising or falling edge
module pis_line_edge (
  input wire logic pair_bit,
  input wire logic pol_bit,
  input wire logic rise_a,
  input wire logic fall_a,
  input wire logic rise_d,
  input wire logic fall_d,
  output logic evt
);
  logic pin_r;
  logic pin_f;

  // pair bit high takes the port D pin
  assign pin_r = pair_bit ? rise_d : rise_a;
  assign pin_f = pair_bit ? fall_d : fall_a;
  // polarity bit high takes the rising edge, low the falling one
  assign evt = pol_bit ? pin_r : pin_f;
endmodule

// both-edge pick for the comparator and the port C pins
module pis_both_edge (
  input wire logic rise_in,
  input wire logic fall_in,
  output logic evt
);
  // either transition counts as one event
  assign evt = rise_in | fall_in;
endmodule
`default_nettype wire

// File: bench/pis_irq_select_sva.sv
// assertion checker for the pin irq source selector
`timescale 1ns/1ps
`default_nettype none
module pis_irq_select_sva
  import pis_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire pis_apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_exc,
  input wire logic irq_out,
  input wire logic [3:0] irq_id,
  input wire logic [1:0] irq_level,
  input wire logic exc_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic rd_aux;
  logic rd_pc;
  logic clr_exc;
  // decode of completed register transfers
  assign rd_aux = pready && !apb_req.pwrite && apb_req.paddr == {PIS_IDX_AUX_SEL[29:0], 2'b00};
  assign rd_pc = pready && !apb_req.pwrite && apb_req.paddr == {PIS_IDX_PC_SEL[29:0], 2'b00};
  assign clr_exc = pready && apb_req.pwrite && apb_req.paddr == {PIS_IDX_EXC[29:0], 2'b00} && apb_req.pwdata[0];
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_delay: assert property (apb_req.psel && !apb_req.penable |-> ##2 pready)
    else $error("pready not in second access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_aux_reserved: assert property (rd_aux |-> prdata[31:8] == 24'h0 && prdata[6:1] == 6'h00)
    else $error("aux select reserved bits not zero");
  a_pc_reserved: assert property (rd_pc |-> prdata[31:4] == 28'h0)
    else $error("port c select reserved bits not zero");
  a_exc_follows: assert property (sys_exc |=> exc_out)
    else $error("exception not passed on");
  a_exc_sticky: assert property (exc_out && !clr_exc && !$past(clr_exc) |=> exc_out)
    else $error("exception dropped without clear");
  a_level_legal: assert property (irq_out |-> irq_level != 2'h3)
    else $error("illegal priority level");
  a_id_legal: assert property (irq_out |-> irq_id < 4'hc)
    else $error("line number out of range");
endmodule
bind pis_irq_select pis_irq_select_sva chk_u (.clock(clock), .rst(rst), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_exc(sys_exc), .irq_out(irq_out),
  .irq_id(irq_id), .irq_level(irq_level), .exc_out(exc_out));
`default_nettype wire

// File: bench/pis_cpu_model.sv
// cpu core model that acknowledges a request, then waits a service delay before the next
`timescale 1ns/1ps
`default_nettype none
module pis_cpu_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [2:0] dly,
  input wire logic irq_out,
  output logic irq_ack
);
  logic [3:0] cnt;
  logic take;
  assign take = go && irq_out && cnt == 4'h0;
  // one ack, then wait long enough for the vector to refresh
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= take;
      cnt <= take ? {1'b1, dly} : cnt - {3'h0, cnt != 4'h0};
    end
  end
endmodule
`default_nettype wire

// File: bench/pis_irq_select_tb.sv
// self-checking bench for the pin irq source selector
`timescale 1ns/1ps
`default_nettype none
module pis_irq_select_tb
  import pis_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic dbg_req = 1'b0;
  logic sys_exc = 1'b0;
  logic go = 1'b0;
  logic db;
  logic [3:0] dma_done = 4'h0;
  logic [3:0] dm;
  logic [2:0] dly = 3'h0;
  pis_apb_req_s req = '0;
  pis_pins_s pins = '0;
  pis_pins_s old;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq_ack, irq_out, exc_out, er;
  logic [3:0] irq_id;
  logic [1:0] irq_level;
  logic [7:0] ax, pr, ed, pc;
  logic [31:0] sel [4] = '{PIS_IDX_AUX_SEL, PIS_IDX_PAIR_SEL, PIS_IDX_EDGE_POL, PIS_IDX_PC_SEL};
  int errors = 0;
  int check_count = 0;
  pis_irq_select dut_u (.clock(clock), .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .dbg_req(dbg_req), .dma_done(dma_done), .sys_exc(sys_exc),
    .irq_ack(irq_ack), .irq_out(irq_out), .irq_id(irq_id), .irq_level(irq_level), .exc_out(exc_out));
  pis_cpu_model cpu_u (.clock(clock), .rst(rst), .go(go), .dly(dly), .irq_out(irq_out), .irq_ack(irq_ack));
  // 200 MHz clock
  initial forever #2.5 clock = ~clock;
  task automatic test_done;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] i, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {i[29:0], 2'b00}, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rq = prdata;
    re = pslverr;
    req <= '0;
    @(posedge clock);
    if (n >= 20) begin
      errors++;
      test_done;
    end
  endtask
  task automatic wr(input logic [31:0] i, input logic [31:0] d);
    apb(1'b1, i, d, q, er);
    chk({31'h0, er}, 32'h0);
  endtask
  task automatic rd(input logic [31:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0, q, er);
    chk(q, e);
  endtask
  // pending bits expected from one change of pins and event pulses
  function automatic logic [31:0] exp_pend(pis_pins_s o, pis_pins_s n);
    logic [11:0] r;
    logic so, sn;
    for (int x = 0; x < 8; x++) begin
      so = pr[x] ? o.port_d[x] : o.port_a[x];
      sn = pr[x] ? n.port_d[x] : n.port_a[x];
      r[x] = ed[x] ? (!so && sn) : (so && !sn);
    end
    if (ax[7]) r[7] = o.comparator != n.comparator;
    if (ax[0]) r[0] = db;
    for (int x = 0; x < 4; x++) r[8 + x] = pc[x] ? o.port_c[x] != n.port_c[x] : dm[x];
    return {20'h0, r};
  endfunction
  // main sequence
  initial begin
    void'($urandom(86));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    foreach (sel[i]) rd(sel[i], 32'h0);
    apb(1'b0, 32'h0, 32'h0, q, er);
    chk({31'h0, er}, 32'h1);
    for (int k = 0; k < 12; k++) begin
      ax = (k == 0) ? 8'h81 : 8'($urandom) & PIS_AUX_WMASK;
      pr = (k == 0) ? 8'hff : 8'($urandom);
      ed = (k == 0) ? 8'hff : 8'($urandom);
      pc = (k == 0) ? 8'h0f : 8'($urandom) & PIS_PC_WMASK;
      wr(PIS_IDX_AUX_SEL, {24'h0, ax});
      wr(PIS_IDX_PAIR_SEL, {24'h0, pr});
      wr(PIS_IDX_EDGE_POL, {24'h0, ed});
      wr(PIS_IDX_PC_SEL, {24'h0, pc});
      rd(PIS_IDX_AUX_SEL, {24'h0, ax});
      rd(PIS_IDX_PC_SEL, {24'h0, pc});
      repeat (4) @(posedge clock);
      wr(PIS_IDX_PENDING, 32'hfff);
      old = pins;
      dm = 4'($urandom);
      db = 1'($urandom);
      pins <= 21'($urandom);
      dma_done <= dm;
      dbg_req <= db;
      @(posedge clock);
      dma_done <= 4'h0;
      dbg_req <= 1'b0;
      repeat (6) @(posedge clock);
      rd(PIS_IDX_PENDING, exp_pend(old, pins));
    end
    // line 8 at high level must win over line 7
    wr(PIS_IDX_PENDING, 32'hfff);
    wr(PIS_IDX_MASK, 32'hfff);
    wr(PIS_IDX_PRIORITY, 32'h20000);
    wr(PIS_IDX_SW_SET, 32'h180);
    repeat (3) @(posedge clock);
    rd(PIS_IDX_PENDING, 32'h180);
    rd(PIS_IDX_VECTOR, 32'h68);
    chk({25'h0, irq_out, irq_level, irq_id}, 32'h68);
    dly <= 3'($urandom);
    go <= 1'b1;
    repeat (40) @(posedge clock);
    rd(PIS_IDX_PENDING, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    // exceptions pass with every line masked
    wr(PIS_IDX_MASK, 32'h0);
    sys_exc <= 1'b1;
    @(posedge clock);
    sys_exc <= 1'b0;
    repeat (2) @(posedge clock);
    chk({31'h0, exc_out}, 32'h1);
    rd(PIS_IDX_EXC, 32'h1);
    wr(PIS_IDX_EXC, 32'h1);
    rd(PIS_IDX_EXC, 32'h0);
    chk({31'h0, exc_out}, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
